// [pat_pkg.sv]
`default_nettype none
package pat_pkg;
   // register word indices, byte address is four times these
   localparam logic [9:0] IDX_DUTY3 = 10'h031;
   localparam logic [9:0] IDX_DUTY0 = 10'h034;
   localparam logic [9:0] IDX_PWMCTL = 10'h035;
   localparam logic [9:0] IDX_CSR = 10'h036;
   localparam logic [9:0] IDX_CAR = 10'h037;
   localparam logic [9:0] IDX_ARR = 10'h038;
   localparam logic [9:0] IDX_ICCSR = 10'h039;
   localparam logic [9:0] IDX_ICR1 = 10'h03a;
   localparam logic [9:0] IDX_ICR2 = 10'h03b;
   // control/status field positions
   localparam int CSR_EXTERNAL_CLOCK_SELECT = 7;
   localparam int CSR_CC_LSB = 4;
   localparam int CSR_TCE = 3;
   localparam int CSR_FORCE_RELOAD = 2;
   localparam int CSR_OIE = 1;
   localparam int CSR_OVF = 0;
   // pwm control field positions
   localparam int PWMCTL_OE_LSB = 4;
   localparam int PWMCTL_OP_LSB = 0;
   // capture control field positions
   localparam int ICCSR_CS_LSB = 4;
   localparam int ICCSR_CIE_LSB = 2;
   localparam int ICCSR_CF_LSB = 0;
   // reset values and counter limits
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [6:0] PRESC_RESET = 7'h00;
   localparam logic [7:0] CNT_TOP = 8'hff;
   localparam logic [6:0] PRESC_FULL = 7'h7f;
endpackage
`default_nettype wire

// [pat_edge_sync.sv]
`default_nettype none
// two-flop synchroniser with edge pulses
module pat_edge_sync (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic pinIn,
   output logic      rise,
   output logic      fall
);
   logic s1_ff; // first stage, read by s2 only
   logic s2_ff; // synchronised level
   logic s3_ff; // previous synchronised level

   // shift chain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // one-cycle edge pulses
   assign rise = s2_ff & ~s3_ff;
   assign fall = ~s2_ff & s3_ff;
endmodule
`default_nettype wire

// [pat_pwm_chan.sv]
`default_nettype none
// one pwm channel: compare shadow and output level
module pat_pwm_chan (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] cnt,
   input  wire logic [7:0] dutyValue,
   input  wire logic       ovfEvt,
   input  wire logic       polarity,
   input  wire logic       haltMode,
   output logic            pwm_ff
);
   logic [7:0] shadow_ff; // compare shadow, hidden from software

   // shadow reload and output level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shadow_ff <= pat_pkg::REG_RESET;
         pwm_ff    <= 1'b0;
      end else begin
         if (ovfEvt) begin
            shadow_ff <= dutyValue;
         end
         if (!haltMode) begin
            pwm_ff <= (cnt <= shadow_ff) ^ polarity;
         end
      end
   end

   shadow_load_a: assert property (@(posedge clk) disable iff (!arst_n)
      ovfEvt |=> shadow_ff == $past(dutyValue)) else $error("shadow not loaded at overflow");
   pwm_level_a: assert property (@(posedge clk) disable iff (!arst_n)
      !haltMode |=> pwm_ff == (($past(cnt) <= $past(shadow_ff)) ^ $past(polarity)))
      else $error("pwm level wrong");
   pwm_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
      haltMode |=> $stable(pwm_ff)) else $error("pwm moved in halt");
endmodule
`default_nettype wire

// [pat_top.sv]
`default_nettype none
// auto-reload pwm timer with apb slave
module pat_top (
   input  wire logic        clk,
   input  wire logic        arst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // system and pins
   input  wire logic        haltMode,
   input  wire logic        extClkIn,
   input  wire logic [1:0]  captureIn,
   output logic      [3:0]  pwmOut,
   output logic      [3:0]  pwmOutEn,
   output logic             ovfIrq,
   output logic             captureIrq,
   output logic             wakeup
);
   // ---------------- registers ----------------
   logic [7:0]  duty_ff [4];     // duty value per channel
   logic [7:0]  pwmCtl_ff;       // enables and polarities
   logic [7:0]  csrCfg_ff;       // stored control bits
   logic        ovf_ff;          // overflow flag
   logic [7:0]  arr_ff;          // auto-reload value
   logic [7:0]  cnt_ff;          // live counter
   logic [6:0]  presc_ff;        // hidden prescaler
   logic [1:0]  capEdge_ff;      // edge select per capture
   logic [1:0]  capIe_ff;        // capture irq enables
   logic [1:0]  capFlag_ff;      // capture flags
   logic [7:0]  capVal_ff [2];   // captured values
   logic [1:0]  capPrev_ff;      // raw pin history for wake
   logic [31:0] prdata_ff;       // read data
   logic        pready_ff;       // access phase ready
   logic        pslverr_ff;      // unmapped answer
   logic        ovfIrq_ff;       // overflow request
   logic        capIrq_ff;       // capture request
   logic        wake_ff;         // halt wake request

   // ---------------- apb decode ----------------
   wire       setupPh  = psel & ~penable;
   wire       accDone  = psel & penable & pready_ff & ~pslverr_ff;
   wire       wrDone   = accDone & pwrite;
   wire       rdDone   = accDone & ~pwrite;
   wire [9:0] wordIdx  = paddr[11:2];
   wire       aligned  = (paddr[1:0] == 2'b00);
   wire       hitPwm   = aligned & (wordIdx == pat_pkg::IDX_PWMCTL);
   wire       hitCsr   = aligned & (wordIdx == pat_pkg::IDX_CSR);
   wire       hitCar   = aligned & (wordIdx == pat_pkg::IDX_CAR);
   wire       hitArr   = aligned & (wordIdx == pat_pkg::IDX_ARR);
   wire       hitIccsr = aligned & (wordIdx == pat_pkg::IDX_ICCSR);
   wire [1:0] hitIcr   = {aligned & (wordIdx == pat_pkg::IDX_ICR2),
                          aligned & (wordIdx == pat_pkg::IDX_ICR1)};
   wire [3:0] hitDuty;
   wire       anyDuty  = |hitDuty;
   wire       mapped   = anyDuty | hitPwm | hitCsr | hitCar | hitArr | hitIccsr | (|hitIcr);

   // duty registers sit in reverse channel order
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_dutyHit
         assign hitDuty[k] = aligned & (wordIdx == (pat_pkg::IDX_DUTY0 - 10'(k)));
      end
   endgenerate

   // ---------------- field views ----------------
   wire       external_clock_select  = csrCfg_ff[pat_pkg::CSR_EXTERNAL_CLOCK_SELECT];
   wire [2:0] cc    = csrCfg_ff[pat_pkg::CSR_CC_LSB +: 3];
   wire       counter_run_enable   = csrCfg_ff[pat_pkg::CSR_TCE];
   wire       overflow_irq_enable   = csrCfg_ff[pat_pkg::CSR_OIE];
   wire [3:0] pol   = pwmCtl_ff[pat_pkg::PWMCTL_OP_LSB +: 4];

   // ---------------- read mux ----------------
   wire [7:0] dutyRd = ({8{hitDuty[0]}} & duty_ff[0]) | ({8{hitDuty[1]}} & duty_ff[1]) |
                       ({8{hitDuty[2]}} & duty_ff[2]) | ({8{hitDuty[3]}} & duty_ff[3]);
   // force reload reads as zero
   wire [7:0] csrRd  = {csrCfg_ff[7:3], 1'b0, overflow_irq_enable, ovf_ff};
   wire [7:0] iccsrRd = {2'b00, capEdge_ff, capIe_ff, capFlag_ff};
   wire [7:0] rdMux  = anyDuty   ? dutyRd :
                       hitPwm    ? pwmCtl_ff :
                       hitCsr    ? csrRd :
                       hitCar    ? cnt_ff :
                       hitArr    ? arr_ff :
                       hitIccsr  ? iccsrRd :
                       hitIcr[0] ? capVal_ff[0] :
                       hitIcr[1] ? capVal_ff[1] : 8'h00;

   // ---------------- software strobes ----------------
   wire       swCarWr = wrDone & hitCar;
   wire       swForce = wrDone & hitCsr & pwdata[pat_pkg::CSR_FORCE_RELOAD];
   wire       swLoad  = swCarWr | swForce;
   wire       rdCsr   = rdDone & hitCsr;
   wire [1:0] rdIcr   = {2{rdDone}} & hitIcr;

   // ---------------- prescaler and counter ----------------
   logic extRise; // synchronised external clock edge
   pat_edge_sync u_extSync (
      .clk    (clk),
      .arst_n (arst_n),
      .pinIn  (extClkIn),
      .rise   (extRise),
      .fall   ()
   );

   wire       run     = counter_run_enable & ~haltMode;
   wire       inTick  = external_clock_select ? extRise : 1'b1;
   wire [6:0] divMask = pat_pkg::PRESC_FULL >> (3'd7 - cc);
   wire       cntTick = run & inTick & ((presc_ff & divMask) == divMask);
   wire       atTop   = (cnt_ff == pat_pkg::CNT_TOP);
   wire       ovfEvt  = cntTick & atTop & ~swLoad;

   wire [6:0] nxt_presc = swLoad        ? pat_pkg::PRESC_RESET :
                          (run & inTick) ? presc_ff + 7'h01 : presc_ff;
   wire [7:0] nxt_cnt   = swCarWr ? pwdata[7:0] :
                          swForce ? arr_ff :
                          ovfEvt  ? arr_ff :
                          cntTick ? cnt_ff + 8'h01 : cnt_ff;

   // counter state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         presc_ff <= pat_pkg::PRESC_RESET;
         cnt_ff   <= pat_pkg::REG_RESET;
      end else begin
         presc_ff <= nxt_presc;
         cnt_ff   <= nxt_cnt;
      end
   end

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwmCtl_ff  <= pat_pkg::REG_RESET;
         csrCfg_ff  <= pat_pkg::REG_RESET;
         arr_ff     <= pat_pkg::REG_RESET;
         capEdge_ff <= 2'b00;
         capIe_ff   <= 2'b00;
      end else if (wrDone) begin
         if (hitPwm) begin
            pwmCtl_ff <= pwdata[7:0];
         end
         if (hitCsr) begin
            // keep only stored bits, flag is hardware owned
            csrCfg_ff <= {pwdata[7:3], 1'b0, pwdata[pat_pkg::CSR_OIE], 1'b0};
         end
         if (hitArr) begin
            arr_ff <= pwdata[7:0];
         end
         if (hitIccsr) begin
            capEdge_ff <= pwdata[pat_pkg::ICCSR_CS_LSB +: 2];
            capIe_ff   <= pwdata[pat_pkg::ICCSR_CIE_LSB +: 2];
         end
      end
   end

   // duty value registers
   generate
      for (k = 0; k < 4; k++) begin : g_duty
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               duty_ff[k] <= pat_pkg::REG_RESET;
            end else if (wrDone && hitDuty[k]) begin
               duty_ff[k] <= pwdata[7:0];
            end
         end
         // compare shadow and output
         pat_pwm_chan u_chan (
            .clk       (clk),
            .arst_n    (arst_n),
            .cnt       (cnt_ff),
            .dutyValue (duty_ff[k]),
            .ovfEvt    (ovfEvt),
            .polarity  (pol[k]),
            .haltMode  (haltMode),
            .pwm_ff    (pwmOut[k])
         );
      end
   endgenerate

   // ---------------- overflow flag ----------------
   // set wins over read clear
   wire nxt_ovf = ovfEvt | (ovf_ff & ~rdCsr);

   // ---------------- captures ----------------
   logic [1:0] capRise;   // synchronised rising edges
   logic [1:0] capFall;   // synchronised falling edges
   logic [1:0] capLatch;  // capture taken this cycle
   logic [1:0] rawEdge;   // unsynchronised pin edge
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_cap
         pat_edge_sync u_capSync (
            .clk    (clk),
            .arst_n (arst_n),
            .pinIn  (captureIn[c]),
            .rise   (capRise[c]),
            .fall   (capFall[c])
         );
         // edge select, halt inhibit, blocked while flag held
         assign capLatch[c] = (capEdge_ff[c] ? capRise[c] : capFall[c]) & ~haltMode &
                              (~capFlag_ff[c] | rdIcr[c]);
         assign rawEdge[c] = capEdge_ff[c] ? (captureIn[c] & ~capPrev_ff[c])
                                           : (~captureIn[c] & capPrev_ff[c]);
         // captured value and flag
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               capVal_ff[c]  <= pat_pkg::REG_RESET;
               capFlag_ff[c] <= 1'b0;
            end else begin
               if (capLatch[c]) begin
                  capVal_ff[c] <= cnt_ff;
               end
               capFlag_ff[c] <= capLatch[c] | (capFlag_ff[c] & ~rdIcr[c]);
            end
         end
         cap_block_a: assert property (@(posedge clk) disable iff (!arst_n)
            (capFlag_ff[c] && !rdIcr[c]) |=> $stable(capVal_ff[c]))
            else $error("capture overwritten while flagged");
      end
   endgenerate

   // ---------------- requests and apb answer ----------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_ff     <= 1'b0;
         capPrev_ff <= 2'b00;
         ovfIrq_ff  <= 1'b0;
         capIrq_ff  <= 1'b0;
         wake_ff    <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         ovf_ff     <= nxt_ovf;
         capPrev_ff <= captureIn;
         ovfIrq_ff  <= nxt_ovf & overflow_irq_enable;
         capIrq_ff  <= |(capIe_ff & (capFlag_ff | capLatch));
         wake_ff    <= haltMode & (|(capIe_ff & rawEdge));
         pready_ff  <= setupPh;
         pslverr_ff <= setupPh & ~mapped;
         if (setupPh) begin
            prdata_ff <= {24'h00_0000, rdMux};
         end
      end
   end

   // ---------------- outputs ----------------
   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign pwmOutEn   = pwmCtl_ff[pat_pkg::PWMCTL_OE_LSB +: 4];
   assign ovfIrq     = ovfIrq_ff;
   assign captureIrq = capIrq_ff;
   assign wakeup     = wake_ff;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_overflow;
      ovfEvt;
   endsequence

   // flag up, request follows the enable seen at the overflow edge; a status read
   // one cycle later may already have dropped both, so only one cycle is judged
   sequence s_flagged;
      ovf_ff && (ovfIrq_ff || !$past(overflow_irq_enable));
   endsequence

   cnt_step_a: assert property (
      (cntTick && !atTop && !swLoad) |=> cnt_ff == $past(cnt_ff) + 8'h01)
      else $error("counter did not step");
   reload_value_a: assert property (
      s_overflow |=> (cnt_ff == $past(arr_ff)) && (presc_ff == $past(presc_ff) + 7'h01))
      else $error("overflow reload wrong");
   run_freeze_a: assert property (
      (!counter_run_enable && !swLoad) |=> $stable(cnt_ff) && $stable(presc_ff))
      else $error("frozen counter moved");
   load_clear_a: assert property (
      swLoad |=> presc_ff == 7'h00) else $error("prescaler not cleared");
   ovf_flag_a: assert property (
      s_overflow |=> s_flagged) else $error("overflow flag or request missing");
   ovf_clear_a: assert property (
      (rdCsr && !ovfEvt) |=> !ovf_ff) else $error("read did not clear flag");
   force_reload_zero_a: assert property (
      (pready_ff && hitCsr && !pwrite) |-> !prdata_ff[pat_pkg::CSR_FORCE_RELOAD])
      else $error("force reload read nonzero");
   halt_capture_a: assert property (
      haltMode |=> $stable(capVal_ff[0]) && $stable(capVal_ff[1]))
      else $error("capture during halt");
endmodule
`default_nettype wire

// [pat_pin_model.sv]
`default_nettype none
// pin-side model: event clock source, capture pins, pwm observer
module pat_pin_model (
   input  wire logic [3:0] pwmOut,
   input  wire logic       clk,
   output logic            extClkIn,
   output logic      [1:0] captureIn
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins idle low, event clock stands still outside pulses
   initial begin
      extClkIn  = 1'b0;
      captureIn = 2'b00;
   end

   // n slow event pulses, four clocks high and at least four low for the sync
   task automatic pulse_ext(input int n);
      repeat (n) begin
         @(posedge clk);
         extClkIn <= 1'b1;
         repeat (4) @(posedge clk);
         extClkIn <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   // move one capture pin to a new level just after an edge
   task automatic set_cap(input int ch, input logic lvl);
      @(posedge clk);
      captureIn[ch] <= lvl;
   endtask

   // count clocks with the pwm pin high over a window
   task automatic count_high(input int ch, input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(posedge clk);
         if (pwmOut[ch] === 1'b1) begin
            cnt++;
         end
      end
   endtask
endmodule
`default_nettype wire

// [tb_pwm_auto_reload_timer.sv]
`default_nettype none
module tb_pwm_auto_reload_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic        haltMode, extClkIn, ovfIrq, captureIrq, wakeup;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  captureIn;
   logic [3:0]  pwmOut, pwmOutEn;
   int          n_mismatch, n_compared;

   pat_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .haltMode(haltMode), .extClkIn(extClkIn), .captureIn(captureIn), .pwmOut(pwmOut),
      .pwmOutEn(pwmOutEn), .ovfIrq(ovfIrq), .captureIrq(captureIrq), .wakeup(wakeup));
   pat_pin_model pin_u (.pwmOut(pwmOut), .clk(clk), .extClkIn(extClkIn), .captureIn(captureIn));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check(32'h0, 32'h1);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, d, rd, err);
   endtask

   task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 8'h00, rd, err);
      check(rd, {24'h0, e});
   endtask

   // reset values and an unmapped word
   task automatic t_reset();
      logic [31:0] rd;
      logic        err;
      rdchk(pat_pkg::IDX_CSR, 8'h00);
      rdchk(pat_pkg::IDX_CAR, 8'h00);
      rdchk(pat_pkg::IDX_ICCSR, 8'h00);
      check({28'h0, pwmOutEn}, 32'h0);
      // counter 00 is not above compare 00, so every pin sits at its active level
      check({28'h0, pwmOut}, 32'hf);
      apb(1'b0, 10'h03c, 8'h00, rd, err);
      check({31'h0, err}, 32'h1);
   endtask

   // counter held while stopped, then one tick per 128 clocks
   task automatic t_counter();
      wr(pat_pkg::IDX_CAR, 8'h5a);
      repeat (8) @(posedge clk);
      rdchk(pat_pkg::IDX_CAR, 8'h5a);
      wr(pat_pkg::IDX_CSR, 8'h78);
      rdchk(pat_pkg::IDX_CAR, 8'h5a);
      repeat (180) @(posedge clk);
      rdchk(pat_pkg::IDX_CAR, 8'h5b);
      wr(pat_pkg::IDX_CSR, 8'h00);
   endtask

   // pwm period 16, duty f8, both polarities, halt freeze, overflow flag
   task automatic t_pwm();
      int   cnt;
      logic lvl;
      wr(pat_pkg::IDX_ARR, 8'hf0);
      wr(pat_pkg::IDX_DUTY0, 8'hf8);
      wr(pat_pkg::IDX_PWMCTL, 8'h10);
      wr(pat_pkg::IDX_CSR, 8'h0e);
      repeat (40) @(posedge clk);
      pin_u.count_high(0, 160, cnt);
      check(32'(cnt), 32'd90);
      check({28'h0, pwmOutEn}, 32'h1);
      check({31'h0, ovfIrq}, 32'h1);
      wr(pat_pkg::IDX_PWMCTL, 8'h11);
      repeat (4) @(posedge clk);
      pin_u.count_high(0, 160, cnt);
      check(32'(cnt), 32'd70);
      haltMode <= 1'b1;
      repeat (4) @(posedge clk);
      lvl = pwmOut[0];
      pin_u.count_high(0, 48, cnt);
      check(32'(cnt), lvl ? 32'd48 : 32'd0);
      haltMode <= 1'b0;
      // stop counting with force reload set, so the read below proves it reads zero
      wr(pat_pkg::IDX_CSR, 8'h06);
      rdchk(pat_pkg::IDX_CSR, 8'h03);
      rdchk(pat_pkg::IDX_CSR, 8'h02);
      repeat (2) @(posedge clk);
      check({31'h0, ovfIrq}, 32'h0);
   endtask

   // rising capture, blocked second capture, falling capture
   task automatic t_capture();
      wr(pat_pkg::IDX_CAR, 8'h33);
      wr(pat_pkg::IDX_ICCSR, 8'h14);
      pin_u.set_cap(0, 1'b1);
      repeat (6) @(posedge clk);
      check({31'h0, captureIrq}, 32'h1);
      rdchk(pat_pkg::IDX_ICCSR, 8'h15);
      wr(pat_pkg::IDX_CAR, 8'h44);
      pin_u.set_cap(0, 1'b0);
      pin_u.set_cap(0, 1'b1);
      repeat (6) @(posedge clk);
      check({31'h0, captureIrq}, 32'h1);
      rdchk(pat_pkg::IDX_ICR1, 8'h33);
      repeat (2) @(posedge clk);
      check({31'h0, captureIrq}, 32'h0);
      wr(pat_pkg::IDX_ICCSR, 8'h08);
      pin_u.set_cap(1, 1'b1);
      repeat (6) @(posedge clk);
      rdchk(pat_pkg::IDX_ICCSR, 8'h08);
      pin_u.set_cap(1, 1'b0);
      repeat (6) @(posedge clk);
      rdchk(pat_pkg::IDX_ICCSR, 8'h0a);
      rdchk(pat_pkg::IDX_ICR2, 8'h44);
   endtask

   // halt with counter stopped: pin edge wakes, no capture latched
   task automatic t_wake();
      logic seen;
      seen = 1'b0;
      wr(pat_pkg::IDX_ICCSR, 8'h28);
      haltMode <= 1'b1;
      pin_u.set_cap(1, 1'b1);
      repeat (8) begin
         @(posedge clk);
         seen = seen | (wakeup === 1'b1);
      end
      haltMode <= 1'b0;
      check({31'h0, seen}, 32'h1);
      rdchk(pat_pkg::IDX_ICCSR, 8'h28);
   endtask

   // external events: overflow after 256 minus fd events
   task automatic t_event();
      wr(pat_pkg::IDX_ARR, 8'hfd);
      wr(pat_pkg::IDX_CSR, 8'h8c);
      pin_u.pulse_ext(2);
      repeat (6) @(posedge clk);
      rdchk(pat_pkg::IDX_CSR, 8'h88);
      pin_u.pulse_ext(1);
      repeat (6) @(posedge clk);
      rdchk(pat_pkg::IDX_CSR, 8'h89);
      rdchk(pat_pkg::IDX_CAR, 8'hfd);
   endtask

   // verdict
   task automatic complete_run();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   // main sequence
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      arst_n   = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      haltMode = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_counter();
      t_pwm();
      t_capture();
      t_wake();
      t_event();
      complete_run();
   end
endmodule
`default_nettype wire
